// *** aics_pkg.sv ***
// Notes on behaviour
// R1: Positive code picks port pin, sensor, supply
// R2: Negative code picks port pin, reference, ground
// R3: Negative ground code means single-ended mode
// R4: Any other negative code means differential
// R5: Positive select answers at 0xbb, all pages
// R6: Negative select answers at 0xba, all pages
// R7: Codes 10110 to 11111 connect nothing
// R8: Upper three bits read zero, writes ignored
// R9: Sensor read only positive, ground negative
// R10: Software selects sensor code for temperature
// R11: Sensor enable bit powers sensor on/off
// R12: Disabled sensor output floats, data invalid
package aics_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register addresses on the special-function bus
    localparam logic [7:0] ADDR_NEG = 8'hba;
    localparam logic [7:0] ADDR_POS = 8'hbb;
    // Reference control address, not on this block's own map
    localparam logic [7:0] ADDR_REF = 8'hd1;
    // Sensor enable bit position in the reference control register
    localparam int         REF_TEMP_BIT = 2;

    // Reset value of the selection fields, and read value of the unused bits
    localparam logic [4:0] SEL_RESET = 5'h1f;
    localparam logic [2:0] UNUSED_READ = 3'h0;

    ////////////////////////////////////////////////////////////////////////
    // Channel codes
    localparam logic [4:0] CODE_PORT_LAST = 5'h0f;
    localparam logic [4:0] CODE_SPECIAL_A = 5'h10;
    localparam logic [4:0] CODE_SPECIAL_B = 5'h11;
    localparam logic [4:0] CODE_P2_FIRST  = 5'h12;
    localparam logic [4:0] CODE_P2_LAST   = 5'h15;

    // Decoded select lines for one multiplexer leg
    typedef struct packed {
        logic [15:0] port01;   // Port 0 pins 0..7, port 1 pins 0..7
        logic [3:0]  port2;    // Port 2 pins 0..3
        logic        special_a; // Sensor (positive) or reference (negative)
        logic        special_b; // Supply (positive) or ground (negative)
    } aics_sel_s;

endpackage : aics_pkg

// *** aics_decode.sv ***
`timescale 1ns/10ps
// One-hot decoder for a five-bit multiplexer code
module aics_decode
(
    // Code in
    input  wire logic [4:0]         code,
    // Select lines out
    output aics_pkg::aics_sel_s     sel
);

    ////////////////////////////////////////////////////////////////////////
    // Decoding; unassigned codes leave every line low
    always_comb
    begin
        sel = '0;
        // R1: Port 0 and port 1 pins
        if (code <= aics_pkg::CODE_PORT_LAST)
        begin
            sel.port01[code[3:0]] = 1'b1;
        end
        // R2: Sensor or reference slot
        else if (code == aics_pkg::CODE_SPECIAL_A)
        begin
            sel.special_a = 1'b1;
        end
        // R3: Supply or ground slot
        else if (code == aics_pkg::CODE_SPECIAL_B)
        begin
            sel.special_b = 1'b1;
        end
        // R1: Port 2 pins on larger packages
        else if (code >= aics_pkg::CODE_P2_FIRST && code <= aics_pkg::CODE_P2_LAST)
        begin
            sel.port2[2'(code - aics_pkg::CODE_P2_FIRST)] = 1'b1;
        end
        // R7: Remaining codes select nothing
        else
        begin
            sel = '0;
        end
    end

endmodule : aics_decode

// *** aics_top.sv ***
`timescale 1ns/10ps
// Input channel selection registers for the converter multiplexer
module aics_top
(
    // Clock and reset
    input  wire logic               clock,
    input  wire logic               rst_n,
    // Special-function register bus
    input  wire logic [7:0]         sfr_addr,
    input  wire logic [7:0]         sfr_wdata,
    input  wire logic               sfr_wr,
    input  wire logic               sfr_rd,
    output logic      [7:0]         sfr_rdata,
    output logic                    sfr_hit,
    // Multiplexer select lines
    output aics_pkg::aics_sel_s     pos_sel,
    output aics_pkg::aics_sel_s     neg_sel,
    // Converter mode and sensor control
    output logic                    single_ended,
    output logic                    temp_sensor_enable,
    output logic                    temp_measure_valid
);

    ////////////////////////////////////////////////////////////////////////
    // Register state
    logic [4:0]          pos_q, pos_d;     // Positive selection field
    logic [4:0]          neg_q, neg_d;     // Negative selection field
    logic                ten_q, ten_d;     // Sensor enable copy
    logic [7:0]          rd_q, rd_d;       // Read data
    logic                hit_q, hit_d;     // Address hit on read
    aics_pkg::aics_sel_s pos_dec, neg_dec; // Decoded from next values
    aics_pkg::aics_sel_s psel_q, nsel_q;   // Registered select lines
    logic                se_q, se_d;       // Single-ended mode flag
    logic                tv_q, tv_d;       // Sensor reading trustworthy

    ////////////////////////////////////////////////////////////////////////
    // Address match, shared by the write and read paths
    function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] want);
        addr_is = (addr == want);
    endfunction : addr_is

    // Decoders look at next values so outputs align with the register
    aics_decode u_pos (.code(pos_d), .sel(pos_dec));
    aics_decode u_neg (.code(neg_d), .sel(neg_dec));

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic; page register is ignored entirely
    always_comb
    begin
        pos_d = pos_q;
        neg_d = neg_q;
        ten_d = ten_q;
        rd_d  = 8'h00;
        hit_d = 1'b0;
        if (sfr_wr)
        begin
            // R5: Positive select, any page
            // R8: Upper bits dropped on write
            if (addr_is(sfr_addr, aics_pkg::ADDR_POS))
            begin
                pos_d = sfr_wdata[4:0];
            end
            // R6: Negative select, any page
            if (addr_is(sfr_addr, aics_pkg::ADDR_NEG))
            begin
                neg_d = sfr_wdata[4:0];
            end
            // R11: Sensor enable in reference control
            if (addr_is(sfr_addr, aics_pkg::ADDR_REF))
            begin
                ten_d = sfr_wdata[aics_pkg::REF_TEMP_BIT];
            end
        end
        if (sfr_rd)
        begin
            // R8: Unused bits read zero
            if (addr_is(sfr_addr, aics_pkg::ADDR_POS))
            begin
                rd_d  = {aics_pkg::UNUSED_READ, pos_q};
                hit_d = 1'b1;
            end
            else if (addr_is(sfr_addr, aics_pkg::ADDR_NEG))
            begin
                rd_d  = {aics_pkg::UNUSED_READ, neg_q};
                hit_d = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode group: follows the next field values so that mode and select
    // lines change on the same edge as the field they describe
    always_comb
    begin
        // R3: Ground on negative gives single-ended
        // R4: Everything else is differential
        se_d = (neg_d == aics_pkg::CODE_SPECIAL_B);
        // R9: Sensor valid only positive sensor, ground negative
        // R12: Disabled sensor floats, so never valid
        tv_d = (pos_d == aics_pkg::CODE_SPECIAL_A) && se_d && ten_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus group registers: fields, sensor enable, read return
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // Idle codes connect nothing until software picks a channel
            pos_q <= aics_pkg::SEL_RESET;
            neg_q <= aics_pkg::SEL_RESET;
            ten_q <= 1'b0;
            rd_q  <= 8'h00;
            hit_q <= 1'b0;
        end
        else
        begin
            pos_q <= pos_d;
            neg_q <= neg_d;
            ten_q <= ten_d;
            rd_q  <= rd_d;
            hit_q <= hit_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode group registers: decoded selects and converter flags
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // All switches open and sensor reading untrusted in reset
            psel_q <= '0;
            nsel_q <= '0;
            se_q   <= 1'b0;
            tv_q   <= 1'b0;
        end
        else
        begin
            psel_q <= pos_dec;
            nsel_q <= neg_dec;
            se_q   <= se_d;
            tv_q   <= tv_d;
        end
    end

    // Outputs straight from flops
    assign sfr_rdata          = rd_q;
    assign sfr_hit            = hit_q;
    assign pos_sel            = psel_q;
    assign neg_sel            = nsel_q;
    assign single_ended       = se_q;
    assign temp_sensor_enable = ten_q;
    assign temp_measure_valid = tv_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    // Register bus requests that the checks below start from
    sequence s_rd_pos;
        sfr_rd && sfr_addr == aics_pkg::ADDR_POS;
    endsequence
    sequence s_rd_neg;
        sfr_rd && sfr_addr == aics_pkg::ADDR_NEG;
    endsequence
    sequence s_wr_ref;
        sfr_wr && sfr_addr == aics_pkg::ADDR_REF;
    endsequence
    a_write_pos: assert property (@(posedge clock) disable iff (!rst_n) // R5
        sfr_wr && sfr_addr == aics_pkg::ADDR_POS |=> pos_q == $past(sfr_wdata[4:0]))
        else $error("positive select write lost");
    a_write_neg: assert property (@(posedge clock) disable iff (!rst_n) // R6
        sfr_wr && sfr_addr == aics_pkg::ADDR_NEG |=> neg_q == $past(sfr_wdata[4:0]))
        else $error("negative select write lost");
    a_read_zero: assert property (@(posedge clock) disable iff (!rst_n) // R8
        sfr_rd |=> sfr_rdata[7:5] == 3'h0)
        else $error("unused bits not zero");
    a_single_gnd: assert property (@(posedge clock) disable iff (!rst_n) // R3
        single_ended == nsel_q.special_b)
        else $error("single-ended mismatch");
    a_diff_mode: assert property (@(posedge clock) disable iff (!rst_n) // R4
        neg_q != aics_pkg::CODE_SPECIAL_B |-> !single_ended)
        else $error("differential not signalled");
    a_none_sel: assert property (@(posedge clock) disable iff (!rst_n) // R7
        pos_q > aics_pkg::CODE_P2_LAST |-> pos_sel == '0)
        else $error("idle code selected input");
    a_sensor_pos: assert property (@(posedge clock) disable iff (!rst_n) // R1
        pos_q == aics_pkg::CODE_SPECIAL_A |-> pos_sel.special_a && $onehot(pos_sel))
        else $error("sensor not selected");
    a_ref_neg: assert property (@(posedge clock) disable iff (!rst_n) // R2
        neg_q == aics_pkg::CODE_SPECIAL_A |-> neg_sel.special_a && $onehot(neg_sel))
        else $error("reference not selected");
    a_sensor_en: assert property (@(posedge clock) disable iff (!rst_n) // R11
        s_wr_ref
        |=> temp_sensor_enable == $past(sfr_wdata[aics_pkg::REF_TEMP_BIT]))
        else $error("sensor enable lost");
    a_temp_valid: assert property (@(posedge clock) disable iff (!rst_n) // R12
        temp_measure_valid == (temp_sensor_enable && single_ended && pos_sel.special_a))
        else $error("sensor measure flag wrong");

    // Read return: old field value, upper bits zero, one cycle only
    a_read_pos: assert property (@(posedge clock) disable iff (!rst_n) // R5
        s_rd_pos |=> sfr_hit && sfr_rdata == {aics_pkg::UNUSED_READ, $past(pos_q)})
        else $error("positive select read wrong");
    a_read_neg: assert property (@(posedge clock) disable iff (!rst_n) // R6
        s_rd_neg |=> sfr_hit && sfr_rdata == {aics_pkg::UNUSED_READ, $past(neg_q)})
        else $error("negative select read wrong");
    a_read_miss: assert property (@(posedge clock) disable iff (!rst_n) // R5
        !(sfr_rd && (sfr_addr == aics_pkg::ADDR_POS || sfr_addr == aics_pkg::ADDR_NEG))
        |=> !sfr_hit && sfr_rdata == 8'h00)
        else $error("read answered without a hit");

    // Fields hold between writes to their own address
    a_hold_pos: assert property (@(posedge clock) disable iff (!rst_n) // R5
        !(sfr_wr && sfr_addr == aics_pkg::ADDR_POS) |=> $stable(pos_q))
        else $error("positive select changed unasked");
    a_hold_neg: assert property (@(posedge clock) disable iff (!rst_n) // R6
        !(sfr_wr && sfr_addr == aics_pkg::ADDR_NEG) |=> $stable(neg_q))
        else $error("negative select changed unasked");
    a_enable_hold: assert property (@(posedge clock) disable iff (!rst_n) // R11
        !(sfr_wr && sfr_addr == aics_pkg::ADDR_REF) |=> $stable(temp_sensor_enable))
        else $error("sensor enable changed unasked");

    // Decoded selects for the ground and supply slots
    a_gnd_neg: assert property (@(posedge clock) disable iff (!rst_n) // R3
        neg_q == aics_pkg::CODE_SPECIAL_B |-> neg_sel.special_b && $onehot(neg_sel))
        else $error("ground not selected");
    a_supply_pos: assert property (@(posedge clock) disable iff (!rst_n) // R1
        pos_q == aics_pkg::CODE_SPECIAL_B |-> pos_sel.special_b && $onehot(pos_sel))
        else $error("supply not selected");

endmodule : aics_top

// *** aics_front_model.sv ***
`timescale 1ns/10ps
// Converter front end as seen from the select lines
module aics_front_model
(
    // Select lines from the block
    input  aics_pkg::aics_sel_s pos_sel,
    input  aics_pkg::aics_sel_s neg_sel,
    input  wire logic           temp_sensor_enable,
    // Closed switches per leg, and the sensor output node
    output logic [4:0]          pos_hot,
    output logic [4:0]          neg_hot,
    output wire                 sensor_node
);
    // one switch per leg at most
    always_comb pos_hot = 5'($countones(pos_sel));
    always_comb neg_hot = 5'($countones(neg_sel));
    // sensor floats while off, so a read of it is junk
    assign sensor_node = temp_sensor_enable ? 1'b1 : 1'bz;
endmodule : aics_front_model

// *** adc_input_channel_select_bench.sv ***
`timescale 1ns/10ps
// Self-checking bench for the channel select registers
module adc_input_channel_select_bench;
    logic                clock, rst_n, sfr_wr, sfr_rd, sfr_hit;
    logic                single_ended, temp_sensor_enable, temp_measure_valid;
    logic [7:0]          sfr_addr, sfr_wdata, sfr_rdata;
    logic [4:0]          pos_hot, neg_hot;
    aics_pkg::aics_sel_s pos_sel, neg_sel;
    wire                 sensor_node;
    int                  miscompares, cmp_count, cycles;

    aics_top uut (.clock(clock), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
        .pos_sel(pos_sel), .neg_sel(neg_sel), .single_ended(single_ended),
        .temp_sensor_enable(temp_sensor_enable), .temp_measure_valid(temp_measure_valid));
    aics_front_model front (.pos_sel(pos_sel), .neg_sel(neg_sel), .temp_sensor_enable(temp_sensor_enable),
        .pos_hot(pos_hot), .neg_hot(neg_hot), .sensor_node(sensor_node));

    // Clock, 100 ns period
    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    // Hang guard, far above the few hundred cycles needed
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            miscompares++;
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Two cycles per access so strobes never toggle twice in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a; sfr_wdata = d; sfr_wr = 1'b1;
        @(posedge clock); #1;
        sfr_wr = 1'b0; sfr_addr = ~a; sfr_wdata = ~d;
        @(posedge clock); #1;
    endtask : wr
    // Read data stands one cycle only, so it is checked at once
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic hit);
        sfr_addr = a; sfr_rd = 1'b1;
        @(posedge clock); #1;
        chk(sfr_rdata, exp);
        chk(sfr_hit, hit);
        sfr_rd = 1'b0; sfr_addr = ~a;
        @(posedge clock); #1;
    endtask : rd
    // Expected one-hot selects for a code
    function automatic aics_pkg::aics_sel_s exp_sel(input logic [4:0] c);
        exp_sel = '0;
        if (c <= 5'h0f) exp_sel.port01[c[3:0]] = 1'b1;
        else if (c == 5'h10) exp_sel.special_a = 1'b1;
        else if (c == 5'h11) exp_sel.special_b = 1'b1;
        else if (c <= 5'h15) exp_sel.port2[2'(c - 5'h12)] = 1'b1;
    endfunction : exp_sel

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd(8'hba, 8'h1f, 1'b1);
        rd(8'hbb, 8'h1f, 1'b1);
        chk(pos_sel, '0);
        chk(neg_sel, '0);
        chk({single_ended, temp_sensor_enable, temp_measure_valid}, 3'h0);
    endtask : t_reset
    // Every positive code, upper bits written as ones
    task automatic t_pos();
        logic [4:0] c;
        for (int i = 0; i < 32; i++)
        begin
            c = 5'(i);
            wr(8'hbb, {3'h7, c});
            chk(pos_sel, exp_sel(c));
            chk(pos_hot, (c < 5'h16) ? 5'h01 : 5'h00);
            rd(8'hbb, {3'h0, c}, 1'b1);
        end
    endtask : t_pos
    // Every negative code, with the mode flag
    task automatic t_neg();
        logic [4:0] c;
        for (int i = 0; i < 32; i++)
        begin
            c = 5'(i);
            wr(8'hba, {3'h5, c});
            chk(neg_sel, exp_sel(c));
            chk(single_ended, c == 5'h11);
            chk(neg_hot, (c < 5'h16) ? 5'h01 : 5'h00);
            rd(8'hba, {3'h0, c}, 1'b1);
        end
    endtask : t_neg
    // Sensor path: enable, differential spoil, disable
    task automatic t_sensor();
        wr(8'hbb, 8'h10);
        wr(8'hba, 8'h11);
        wr(8'hd1, 8'h04);
        chk({temp_sensor_enable, temp_measure_valid, sensor_node}, 3'h7);
        wr(8'hba, 8'h10);
        chk({single_ended, temp_measure_valid}, 2'h0);
        wr(8'hba, 8'h11);
        wr(8'hd1, 8'h00);
        chk({temp_sensor_enable, temp_measure_valid, sensor_node}, 3'b00z);
    endtask : t_sensor
    // Unmapped place: write ignored, read empty
    task automatic t_refuse();
        wr(8'h55, 8'h03);
        rd(8'h55, 8'h00, 1'b0);
        rd(8'hbb, 8'h10, 1'b1);
    endtask : t_refuse
    // Reset in mid-run puts every field back to the idle codes
    task automatic t_midreset();
        wr(8'hbb, 8'h05);
        wr(8'hd1, 8'h04);
        chk(temp_sensor_enable, 1'b1);
        rst_n = 1'b0;
        repeat (2) @(posedge clock);
        #1;
        rst_n = 1'b1;
        t_reset();
    endtask : t_midreset

    task automatic wrap_up();
        $display("compares=%0d miscompares=%0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up

    initial
    begin
        rst_n = 1'b0; sfr_wr = 1'b0; sfr_rd = 1'b0; sfr_addr = 8'h00; sfr_wdata = 8'h00;
        repeat (8) @(posedge clock);
        #1 rst_n = 1'b1;
        t_reset();
        t_pos();
        t_neg();
        t_sensor();
        t_refuse();
        t_midreset();
        wrap_up();
    end
endmodule : adc_input_channel_select_bench
